// >>> hdl/chk_chan_ctrl.sv
// paged channel gain, dc tone, fractional nco and sequence checker
// assumes synchronous inputs on mclk and a one-cycle strobe register port
`include "chk_map.svh"
`timescale 1ns/1ps
`default_nettype none
module chk_chan_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic [47:0] channel_tuning_word,
  input wire logic [47:0] nco_fraction_denominator,
  input wire logic [15:0] delta_low,
  input wire logic [2:0][15:0] chan_i_in,
  input wire logic [2:0][15:0] chan_q_in,
  output logic [2:0][15:0] chan_i_out,
  output logic [2:0][15:0] chan_q_out,
  output logic [2:0][47:0] nco_phase,
  input wire logic [1:0] dac_valid,
  input wire chk_pkg::chk_smp_t dac0_data,
  input wire chk_pkg::chk_smp_t dac1_data,
  output logic [7:0] err_count_dac0,
  output logic [7:0] err_count_dac1
);
  import chk_pkg::*;

  chk_state_s r;
  chk_state_s n;
  logic [2:0][47:0] acc_n;
  logic [2:0][47:0] frac_n;
  logic [2:0][15:0] si;
  logic [2:0][15:0] sq;
  logic [1:0] err;
  logic [1:0] bitv;
  logic [1:0] exp_b;
  logic [1:0] ready;
  logic [1:0] chk_bit;
  logic [1:0] sequence_checker_ctrl_status_in;
  logic [1:0] first;

  function automatic logic [15:0] scale(input logic [15:0] s,
                                        input logic [11:0] g);
    logic signed [29:0] p;
    logic signed [29:0] q;
    p = $signed({{14{s[15]}}, s}) * $signed({18'h00000, g});
    q = p >>> `CHK_GAIN_SH;
    if (q > $signed({14'h0000, `CHK_SMAX})) begin
      scale = `CHK_SMAX;
    end else if (q < $signed({14'h3FFF, `CHK_SMIN})) begin
      scale = `CHK_SMIN;
    end else begin
      scale = q[15:0];
    end
  endfunction : scale

  assign sequence_checker_ctrl_status_in = {dac1_data[0], dac0_data[0]};

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_ch
      logic [47:0] fsum;
      logic wrap;
      // fraction carries one extra lsb into the phase step
      assign fsum = r.frac[c] + {r.delta[c], delta_low};
      assign wrap = fsum >= nco_fraction_denominator;
      assign frac_n[c] = wrap ? fsum - nco_fraction_denominator : fsum;
      assign acc_n[c] = r.fren[c] ?
        r.acc[c] + channel_tuning_word + {47'h0, wrap} :
        r.acc[c] + channel_tuning_word;
      assign si[c] = scale(chan_i_in[c], r.gain[c]);
      assign sq[c] = scale(chan_q_in[c], r.gain[c]);
    end
    for (c = 0; c < 2; c++) begin : g_dac
      // self-synchronising: history is fed by the corrected received bit
      assign chk_bit[c] = sequence_checker_ctrl_status_in[c] ^ r.inv[c];
      assign exp_b[c] = r.mode ? r.hist[c][14] ^ r.hist[c][13]
                               : r.hist[c][6] ^ r.hist[c][5];
      assign ready[c] = r.fill[c] >= (r.mode ? `CHK_FILL15 : `CHK_FILL7);
      assign bitv[c] = dac_valid[c] & r.en & ~r.clr;
      assign err[c] = bitv[c] & ready[c] & (chk_bit[c] != exp_b[c]);
    end
  endgenerate

  always_comb begin
    n = r;
    n.rdata = 8'h00;
    first = 2'h0;
    for (int k = 2; k >= 0; k--) begin
      if (r.page[k]) begin
        first = 2'(k);
      end
    end
    for (int k = 0; k < 3; k++) begin
      n.acc[k] = acc_n[k];
      n.frac[k] = r.fren[k] ? frac_n[k] : 48'h0;
      // dc tone replaces both paths, same code on i and q
      n.iout[k] = r.dcen[k] ? r.dcl[k] : si[k];
      n.qout[k] = r.dcen[k] ? r.dcl[k] : sq[k];
    end
    for (int d = 0; d < 2; d++) begin
      if (bitv[d]) begin
        n.hist[d] = {r.hist[d][13:0], chk_bit[d]};
        if (!ready[d]) begin
          n.fill[d] = r.fill[d] + 4'h1;
        end
      end
      if (err[d]) begin
        n.good[d] = 1'b0;
        if (r.cnt[d] != 8'hFF) begin
          n.cnt[d] = r.cnt[d] + 8'h01;
        end
      end
    end
    if (reg_wr) begin
      for (int k = 0; k < 3; k++) begin
        if (r.page[k]) begin
          unique case (reg_addr)
            `CHK_A_NCOCTL: begin
              n.dcen[k] = reg_wdata[`CHK_B_DCEN];
              n.fren[k] = reg_wdata[`CHK_B_FREN];
            end
            `CHK_A_DELTA2: n.delta[k][7:0] = reg_wdata;
            `CHK_A_DELTA3: n.delta[k][15:8] = reg_wdata;
            `CHK_A_DELTA4: n.delta[k][23:16] = reg_wdata;
            `CHK_A_DELTA5: n.delta[k][31:24] = reg_wdata;
            `CHK_A_GAINL: n.gain[k][7:0] = reg_wdata;
            `CHK_A_GAINH: n.gain[k][11:8] = reg_wdata[3:0];
            `CHK_A_DCL: n.dcl[k][7:0] = reg_wdata;
            `CHK_A_DCH: n.dcl[k][15:8] = reg_wdata;
            default: ;
          endcase
        end
      end
      unique case (reg_addr)
        `CHK_A_PAGE: n.page = reg_wdata[2:0];
        `CHK_A_SEQ: begin
          n.en = reg_wdata[`CHK_B_EN];
          n.clr = reg_wdata[`CHK_B_CLR];
          n.mode = reg_wdata[`CHK_B_MODE];
          n.inv = {reg_wdata[`CHK_B_INV1], reg_wdata[`CHK_B_INV0]};
          // polynomial change restarts the history fill
          if (reg_wdata[`CHK_B_MODE] != r.mode) begin
            n.fill = '0;
          end
        end
        `CHK_A_IRQMSK: n.msk = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (r.clr) begin
      n.cnt = '0;
      n.good = 2'h3;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `CHK_A_PAGE: n.rdata = {5'h00, r.page};
        `CHK_A_NCOCTL: n.rdata = {6'h00, r.fren[first], r.dcen[first]};
        `CHK_A_DELTA2: n.rdata = r.delta[first][7:0];
        `CHK_A_DELTA3: n.rdata = r.delta[first][15:8];
        `CHK_A_DELTA4: n.rdata = r.delta[first][23:16];
        `CHK_A_DELTA5: n.rdata = r.delta[first][31:24];
        `CHK_A_GAINL: n.rdata = r.gain[first][7:0];
        `CHK_A_GAINH: n.rdata = {4'h0, r.gain[first][11:8]};
        `CHK_A_DCL: n.rdata = r.dcl[first][7:0];
        `CHK_A_DCH: n.rdata = r.dcl[first][15:8];
        `CHK_A_SEQ: n.rdata = {r.good, 1'b0, r.inv, r.mode, r.clr, r.en};
        `CHK_A_IRQSTS: n.rdata = {6'h00, r.sts};
        `CHK_A_IRQMSK: n.rdata = {6'h00, r.msk};
        default: n.rdata = 8'h00;
      endcase
      if (reg_addr == `CHK_A_IRQSTS) begin
        n.sts = 2'h0;
      end
    end
    // set wins over the read clear
    for (int d = 0; d < 2; d++) begin
      if (err[d] && r.good[d]) begin
        n.sts[d] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= '0;
      r.page <= `CHK_R_PAGE;
      r.gain <= {3{`CHK_R_GAIN}};
      r.inv <= `CHK_R_INV;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign irq = |(r.sts & r.msk);
  assign chan_i_out = r.iout;
  assign chan_q_out = r.qout;
  assign nco_phase = r.acc;
  assign err_count_dac0 = r.cnt[0];
  assign err_count_dac1 = r.cnt[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_clear;
    r.clr ##1 r.clr;
  endsequence
  sequence s_fail0;
    !r.good[0] && !r.clr;
  endsequence

  a_gain_unity: assert property ($fell(reset) |->
    r.gain[1] == `CHK_R_GAIN) else $error("gain not unity after reset");
  a_good_sticky: assert property (s_fail0 ##1 !r.clr |->
    !r.good[0]) else $error("good flag recovered without clear");
  a_clear_good: assert property (s_clear |->
    r.good == 2'h3 && r.cnt[1] == 8'h00) else $error("clear failed");
  a_err_drop: assert property (err[1] |=>
    !r.good[1]) else $error("mismatch left good flag set");
  a_dc_apply: assert property (r.dcen[1] |=>
    chan_i_out[1] == $past(r.dcl[1]) && chan_q_out[1] == chan_i_out[1])
    else $error("dc level not on both paths");
  a_gain_sat: assert property (!r.dcen[0] &&
    chan_i_in[0] == `CHK_SMAX && r.gain[0] > `CHK_R_GAIN |=>
    chan_i_out[0] == `CHK_SMAX) else $error("gain wrapped");
  a_nco_int: assert property (!r.fren[1] |=>
    nco_phase[1] == $past(r.acc[1] + channel_tuning_word))
    else $error("integer nco step wrong");
  a_nco_frac: assert property (r.fren[0] |=>
    nco_phase[0] - $past(r.acc[0] + channel_tuning_word) <= 48'h1)
    else $error("fractional nco step wrong");
  a_page_keep: assert property (reg_wr && reg_addr == `CHK_A_GAINL &&
    !r.page[1] |=> $stable(r.gain[1])) else $error("unpaged channel hit");
  a_poly_sel: assert property (r.mode && bitv[0] && ready[0] &&
    chk_bit[0] != (r.hist[0][14] ^ r.hist[0][13]) |=> !r.good[0])
    else $error("fifteen-bit check wrong");
  a_inv_reset: assert property ($fell(reset) |->
    r.inv == `CHK_R_INV) else $error("inversion reset wrong");

  // read side: the data word stands one cycle only, reserved bits zero
  sequence s_rd_seq;
    reg_rd && reg_addr == `CHK_A_SEQ;
  endsequence
  sequence s_rd_sts;
    reg_rd && reg_addr == `CHK_A_IRQSTS;
  endsequence

  a_rdata_idle: assert property (!reg_rd |=>
    reg_rdata == 8'h00) else $error("read data outside its cycle");
  a_rd_page: assert property (reg_rd && reg_addr == `CHK_A_PAGE |=>
    reg_rdata == {5'h00, $past(r.page)}) else $error("page readback wrong");
  a_gain_rsvd: assert property (reg_rd && reg_addr == `CHK_A_GAINH |=>
    reg_rdata[7:4] == 4'h0) else $error("gain reserved bits set");
  a_seq_rsvd: assert property (s_rd_seq |=>
    reg_rdata[5] == 1'b0) else $error("checker reserved bit set");
  a_seq_good: assert property (s_rd_seq |=>
    reg_rdata[7:6] == $past(r.good)) else $error("good flags misread");
  a_rd_unmapped: assert property (reg_rd && reg_addr == 12'h000 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");

  // interrupt status: an event in the read-clear cycle must not be lost
  a_sts_keep: assert property (s_rd_sts && err[1] && r.good[1] |=>
    r.sts[1]) else $error("status set lost to read clear");
  a_sts_clear: assert property (s_rd_sts && !(|err) |=>
    r.sts == 2'h0) else $error("status not cleared by read");
  a_irq_rise: assert property (err[0] && r.good[0] && r.msk[0] |=>
    irq) else $error("unmasked event gave no interrupt");
  a_irq_drop: assert property (s_rd_sts && !(|err) |=>
    !irq) else $error("interrupt stayed after read");

  // counters stop at full scale instead of wrapping to zero
  a_cnt_step: assert property (err[0] && r.cnt[0] != 8'hFF |=>
    r.cnt[0] == $past(r.cnt[0]) + 8'h01) else $error("count step wrong");
  a_cnt_sat: assert property (r.cnt[1] == 8'hFF && !r.clr |=>
    r.cnt[1] == 8'hFF) else $error("error count wrapped");
  a_clear_zero: assert property (r.clr |=>
    err_count_dac0 == 8'h00 && err_count_dac1 == 8'h00)
    else $error("clear left counts");
  a_good_hold: assert property (!r.good[1] && !r.clr |=>
    !r.good[1]) else $error("dac1 good recovered without clear");

  // a wrong bit against either generator must drop the flag next cycle
  sequence s_live0;
    bitv[0] && ready[0];
  endsequence
  sequence s_live1;
    bitv[1] && ready[1];
  endsequence

  a_mode7_err: assert property (s_live0 ##0 !r.mode &&
    chk_bit[0] != (r.hist[0][6] ^ r.hist[0][5]) |=> !r.good[0])
    else $error("seven-bit mismatch missed");
  a_mode15_dac1: assert property (s_live1 ##0 r.mode &&
    chk_bit[1] != (r.hist[1][14] ^ r.hist[1][13]) |=> !r.good[1])
    else $error("fifteen-bit mismatch missed");
  a_inv_dac1: assert property (s_live1 ##0 r.inv[1] && !r.mode &&
    dac1_data[0] == (r.hist[1][6] ^ r.hist[1][5]) |=> !r.good[1])
    else $error("uninverted dac1 data passed");
  a_hist_in: assert property (bitv[0] |=>
    r.hist[0][0] == $past(sequence_checker_ctrl_status_in[0] ^ r.inv[0]))
    else $error("history fed wrong bit");
  a_fill_keep: assert property (ready[0] && !(reg_wr &&
    reg_addr == `CHK_A_SEQ) |=> ready[0]) else $error("fill restarted");
  a_mode_wr: assert property (reg_wr && reg_addr == `CHK_A_SEQ |=>
    r.mode == $past(reg_wdata[`CHK_B_MODE])) else $error("mode not taken");

  // datapath: unity gain is exact, zero in gives zero out
  a_gain_pass: assert property (!r.dcen[1] &&
    r.gain[1] == `CHK_R_GAIN |=> chan_i_out[1] == $past(chan_i_in[1]))
    else $error("unity gain changed the sample");
  a_zero_in: assert property (!r.dcen[1] &&
    chan_q_in[1] == 16'h0000 |=> chan_q_out[1] == 16'h0000)
    else $error("dc level leaked while disabled");
  a_neg_sat: assert property (!r.dcen[0] &&
    chan_q_in[0] == `CHK_SMIN && r.gain[0] > `CHK_R_GAIN |=>
    chan_q_out[0] == `CHK_SMIN) else $error("negative gain wrapped");
  a_dc_write: assert property (reg_wr && reg_addr == `CHK_A_DCL &&
    r.page[1] |=> r.dcl[1][7:0] == $past(reg_wdata))
    else $error("paged dc write lost");

  // fraction: cleared while off, carries into the phase when it wraps
  a_frac_off: assert property (!r.fren[2] |=>
    r.frac[2] == 48'h0) else $error("fraction kept while off");
  a_nco_carry: assert property (r.fren[0] &&
    r.frac[0] + {r.delta[0], delta_low} >= nco_fraction_denominator |=>
    nco_phase[0] == $past(r.acc[0] + channel_tuning_word + 48'h1))
    else $error("fraction carry lost");
  a_page_reset: assert property ($fell(reset) |->
    r.page == `CHK_R_PAGE) else $error("page reset wrong");
endmodule : chk_chan_ctrl
`default_nettype wire

// >>> hdl/chk_map.svh
// register offsets, field positions, reset values for the channel control
// assumes an 8-bit register port with a 12-bit byte address
`ifndef CHK_MAP_SVH
`define CHK_MAP_SVH
`define CHK_A_PAGE 12'h008
`define CHK_A_NCOCTL 12'h130
`define CHK_A_DELTA2 12'h142
`define CHK_A_DELTA3 12'h143
`define CHK_A_DELTA4 12'h144
`define CHK_A_DELTA5 12'h145
`define CHK_A_GAINL 12'h146
`define CHK_A_GAINH 12'h147
`define CHK_A_DCL 12'h148
`define CHK_A_DCH 12'h149
`define CHK_A_SEQ 12'h14B
`define CHK_A_IRQSTS 12'h1F0
`define CHK_A_IRQMSK 12'h1F1
`define CHK_B_DCEN 0
`define CHK_B_FREN 1
`define CHK_B_EN 0
`define CHK_B_CLR 1
`define CHK_B_MODE 2
`define CHK_B_INV0 3
`define CHK_B_INV1 4
`define CHK_B_GOOD0 6
`define CHK_B_GOOD1 7
`define CHK_R_GAIN 12'h800
`define CHK_R_INV 2'h2
`define CHK_R_PAGE 3'h7
`define CHK_GAIN_SH 11
`define CHK_FILL7 4'h7
`define CHK_FILL15 4'hF
`define CHK_SMAX 16'h7FFF
`define CHK_SMIN 16'h8000
`endif

// >>> hdl/chk_pkg.sv
// types for the channel datapath control and sequence checker
// assumes three channels and two dac paths
package chk_pkg;
  typedef logic [15:0] chk_smp_t;
  typedef struct packed {
    logic [2:0] page;
    logic [2:0] dcen;
    logic [2:0] fren;
    logic [2:0][31:0] delta;
    logic [2:0][11:0] gain;
    logic [2:0][15:0] dcl;
    logic [2:0][47:0] acc;
    logic [2:0][47:0] frac;
    logic [2:0][15:0] iout;
    logic [2:0][15:0] qout;
    logic [1:0] inv;
    logic mode;
    logic clr;
    logic en;
    logic [1:0] good;
    logic [1:0][7:0] cnt;
    logic [1:0][14:0] hist;
    logic [1:0][3:0] fill;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [7:0] rdata;
  } chk_state_s;
endpackage : chk_pkg

// >>> test/chk_chan_ctrl_tb_top.sv
// bench for chk_chan_ctrl: register port, gain, dc tone, nco, checker
// assumes read data one cycle after the strobe and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module chk_chan_ctrl_tb_top;
  logic mclk, reset, reg_wr, reg_rd, irq, b;
  logic [11:0] reg_addr, g;
  logic [7:0] reg_wdata, reg_rdata, err_count_dac0, err_count_dac1;
  logic [47:0] channel_tuning_word, nco_fraction_denominator, p0;
  logic [15:0] delta_low, dac0_data, dac1_data, x;
  logic [2:0][15:0] chan_i_in, chan_q_in, chan_i_out, chan_q_out;
  logic [2:0][47:0] nco_phase;
  logic [1:0] dac_valid;
  logic [14:0] s;
  integer seed, mismatches, num_checks, k, m;
  integer cyc = 0;

  chk_chan_ctrl chk_chan_ctrl_inst (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq),
    .channel_tuning_word(channel_tuning_word),
    .nco_fraction_denominator(nco_fraction_denominator),
    .delta_low(delta_low), .chan_i_in(chan_i_in), .chan_q_in(chan_q_in),
    .chan_i_out(chan_i_out), .chan_q_out(chan_q_out),
    .nco_phase(nco_phase), .dac_valid(dac_valid), .dac0_data(dac0_data),
    .dac1_data(dac1_data), .err_count_dac0(err_count_dac0),
    .err_count_dac1(err_count_dac1)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask : rd

  // one sequence bit on both paths, dac1 sent inverted, upper bits noise
  task bit_out(input logic bad);
    @(posedge mclk);
    b = (m != 0) ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
    s = {s[13:0], b};
    x = 16'($random(seed));
    dac_valid <= 2'b11;
    dac0_data <= {x[15:1], b ^ bad};
    dac1_data <= {x[15:1], ~b};
  endtask : bit_out

  // saturating gain, the reference for the datapath
  function logic [15:0] scale(input logic [15:0] v, input logic [11:0] gg);
    logic signed [31:0] p;
    p = ($signed(v) * $signed({1'b0, gg})) >>> 11;
    if (p > 32'sh7FFF) scale = 16'h7FFF;
    else if (p < -32'sh8000) scale = 16'h8000;
    else scale = p[15:0];
  endfunction : scale

  task stop_test;
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // a hang costs a mismatch; the whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      stop_test;
    end
  end

  initial begin
    seed = 32'he3e3;
    mismatches = 0;
    num_checks = 0;
    m = 0;
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    dac_valid = 2'b00;
    dac0_data = 16'h0000;
    dac1_data = 16'h0000;
    delta_low = 16'h0001;
    nco_fraction_denominator = 48'h0000_0000_1000;
    channel_tuning_word = 48'h0000_1234_5677;
    chan_i_in = '0;
    chan_q_in = '0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(12'h147, 8'h08);
    rd(12'h146, 8'h00);
    rd(12'h14B, 8'h10);
    rd(12'h1F8, 8'h00);
    p0 = nco_phase[2] + 4 * channel_tuning_word;
    repeat (4) @(posedge mclk);
    #1;
    chk("nco_phase", nco_phase[2][15:0], p0[15:0]);
    wr(12'h008, 8'h01);
    wr(12'h142, 8'h01);
    wr(12'h130, 8'h02);
    #1;
    p0 = nco_phase[0] + 4 * (channel_tuning_word + 48'h1);
    repeat (4) @(posedge mclk);
    #1;
    chk("nco_frac", nco_phase[0][15:0], p0[15:0]);
    // first pass is the overflow corner, the rest random
    for (k = 0; k < 5; k++) begin
      g = (k == 0) ? 12'hFFF : 12'($random(seed));
      x = (k == 0) ? 16'h7FFF : 16'($random(seed));
      wr(12'h146, g[7:0]);
      wr(12'h147, {x[7:4], g[11:8]});
      chan_i_in <= {3{x}};
      chan_q_in <= {3{~x}};
      repeat (2) @(posedge mclk);
      #1;
      chk("gain_i", chan_i_out[0], scale(x, g));
      chk("gain_q", chan_q_out[0], scale(~x, g));
      chk("other_chan", chan_i_out[1], x);
      rd(12'h147, {4'h0, g[11:8]});
    end
    wr(12'h008, 8'h02);
    wr(12'h148, 8'hFF);
    wr(12'h149, 8'h50);
    repeat (2) @(posedge mclk);
    #1;
    chk("dc_off", chan_i_out[1], x);
    wr(12'h130, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    chk("dc_i", chan_i_out[1], 16'h50FF);
    chk("dc_q", chan_q_out[1], 16'h50FF);
    // dac0 masked out of the interrupt in the second pass
    for (m = 0; m < 2; m++) begin
      wr(12'h1F1, (m != 0) ? 8'h02 : 8'h03);
      wr(12'h14B, 8'(8'h12 | (m << 2)));
      wr(12'h14B, 8'(8'h11 | (m << 2)));
      s = 15'($random(seed)) | 15'h0001;
      repeat (40) bit_out(1'b0);
      bit_out(1'b1);
      @(posedge mclk);
      dac_valid <= 2'b00;
      repeat (2) @(posedge mclk);
      #1;
      chk("err0", {8'h00, err_count_dac0}, 16'h0001);
      chk("err1", {8'h00, err_count_dac1}, 16'h0000);
      chk("irq", {15'h0000, irq}, (m != 0) ? 16'h0000 : 16'h0001);
      rd(12'h14B, 8'(8'h91 | (m << 2)));
      rd(12'h1F0, 8'h01);
      chk("irq_clr", {15'h0000, irq}, 16'h0000);
      wr(12'h14B, 8'(8'h12 | (m << 2)));
      @(posedge mclk);
      #1;
      chk("err0_clr", {8'h00, err_count_dac0}, 16'h0000);
      rd(12'h14B, 8'(8'hD2 | (m << 2)));
    end
    stop_test;
  end
endmodule : chk_chan_ctrl_tb_top
`default_nettype wire
